// ===== design/fsr_dev.sv
/*
  Device end: shifts commands in on the link clock, serves the
  discovery table, and applies resume / no-op / reset on the core
  clock once chip select has risen.
  Assumes quad_mode is stable for at least two link clocks before a
  frame, and that the core reports suspends and completion as pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module fsr_dev (
  fsr_if.dev               lnk,               // Link to host
  input  wire logic        clk,               // Core clock
  input  wire logic        rst_n,             // Async reset, low
  input  wire logic        quad_mode,         // Four-lane commands
  input  wire logic        perf_mode,         // Performance mode on
  input  wire logic        prog_suspend_set,  // Program suspended
  input  wire logic        erase_suspend_set, // Erase suspended
  input  wire logic        op_done,           // Operation finished
  output logic             program_suspended_flag, // Suspend status
  output logic             erase_suspended_flag,   // Suspend status
  output logic             busy,              // Write in progress
  output logic             reset_armed,       // Reset arm pending
  output logic             resume_prog,       // Pulse: restart prog
  output logic             resume_erase,      // Pulse: restart erase
  output logic             soft_reset,        // Pulse: reset done
  output logic             op_abort           // Pulse: op killed
);
  // Link-side registers
  logic       frame_rst;
  logic [6:0] cnt_q;
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic       tgl_q;
  logic       long_q;
  logic       quad_s1_q;
  logic       quad_s2_q;
  logic [6:0] op_clks;
  logic       so_q;
  logic       oe_q;
  logic [7:0] ptr_q;
  logic [2:0] nb_q;
  logic       rd_active;
  logic [7:0] cur_byte;
  logic [7:0] lead_byte;
  // Core-side registers
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic       cs_s3_q;
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       tgl_seen_q;
  logic       cmd_end;
  logic       short_cmd;
  logic       do_resume;
  logic       do_reset;

  // Counter, shifter and table driver are cleared whenever the frame closes
  assign frame_rst = lnk.cs_n | ~rst_n;
  assign op_clks   = quad_s2_q ? fsr_pkg::QUAD_OP_CLKS
                               : fsr_pkg::SINGLE_OP_CLKS;
  // Upper lanes are ignored in single-lane mode
  assign rx_d = quad_s2_q ? {rx_q[27:0], lnk.io}
                          : {rx_q[30:0], lnk.io[0]};

  // Mode strap crosses into the link domain
  always_ff @(posedge lnk.sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_s1_q <= 1'b0;
      quad_s2_q <= 1'b0;
    end
    else
    begin
      quad_s1_q <= quad_mode;
      quad_s2_q <= quad_s1_q;
    end
  end

  // Edge counter and input shifter, cleared per frame
  always_ff @(posedge lnk.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      cnt_q <= 7'h00;
      rx_q  <= 32'h0000_0000;
    end
    else
    begin
      if (cnt_q != 7'h7F)
        cnt_q <= cnt_q + 7'h01;
      rx_q <= rx_d;
    end
  end

  // Opcode, address and length flag survive the frame end so the
  // core side can read them after the handshake toggle
  always_ff @(posedge lnk.sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode_q <= 8'h00;
      addr_q   <= 24'h00_0000;
      tgl_q    <= 1'b0;
      long_q   <= 1'b0;
    end
    else
    begin
      if (cnt_q == 7'h00)
        long_q <= 1'b0;
      if (cnt_q + 7'h01 == op_clks)
      begin
        opcode_q <= rx_d[7:0];
        tgl_q    <= ~tgl_q;
      end
      if (cnt_q == op_clks)
        long_q <= 1'b1;
      if (cnt_q + 7'h01 == fsr_pkg::ADDR_DONE_CLKS && !quad_s2_q)
        addr_q <= rx_d[23:0];
    end
  end

  assign rd_active = (opcode_q == fsr_pkg::OP_READ_TABLE) && !quad_s2_q
                     && (cnt_q >= fsr_pkg::DATA_START);
  assign cur_byte  = fsr_pkg::table_byte(ptr_q);
  // First byte of a read, looked up before the pointer is loaded
  assign lead_byte = fsr_pkg::table_byte(addr_q[7:0]);

  // Table data leaves on falling edges; chip select high drops the
  // driver at once, even mid-byte
  always_ff @(negedge lnk.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      so_q  <= 1'b0;
      oe_q  <= 1'b0;
      ptr_q <= 8'h00;
      nb_q  <= 3'h7;
    end
    else if (rd_active)
    begin
      oe_q <= 1'b1;
      if (cnt_q == fsr_pkg::DATA_START)
      begin
        // Addresses past the header area read as unused
        ptr_q <= (addr_q[23:8] == 16'h0000) ? addr_q[7:0]
                                            : fsr_pkg::UNUSED_BYTE;
        so_q  <= (addr_q[23:8] == 16'h0000) ? lead_byte[7]
                                            : 1'b1;
        nb_q  <= 3'h6;
      end
      else
      begin
        so_q <= cur_byte[nb_q];
        if (nb_q == 3'h0)
        begin
          ptr_q <= (ptr_q > fsr_pkg::TABLE_LAST) ? ptr_q
                                                 : ptr_q + 8'h01;
          nb_q  <= 3'h7;
        end
        else
          nb_q <= nb_q - 3'h1;
      end
    end
  end

  assign lnk.dev_io_o  = {2'b00, so_q, 1'b0};
  assign lnk.dev_io_oe = {2'b00, oe_q, 1'b0};

  // Chip select and command toggle cross into the core domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
    end
    else
    begin
      cs_s1_q  <= lnk.cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
    end
  end

  // A command counts once chip select rises after a full opcode
  assign cmd_end   = cs_s2_q && !cs_s3_q && (tgl_s2_q != tgl_seen_q);
  assign short_cmd = cmd_end && !long_q;
  // No write latch check: resume stands on its own
  assign do_resume = short_cmd && opcode_q == fsr_pkg::OP_RESUME
                     && !perf_mode
                     && (program_suspended_flag
                         || erase_suspended_flag);
  assign do_reset  = short_cmd && opcode_q == fsr_pkg::OP_RESET_EXEC
                     && reset_armed;

  // Reset arm: set by arm, any other opcode disarms
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_seen_q  <= 1'b0;
      reset_armed <= 1'b0;
    end
    else if (cmd_end)
    begin
      tgl_seen_q  <= tgl_s2_q;
      reset_armed <= short_cmd
                     && opcode_q == fsr_pkg::OP_RESET_ARM;
    end
  end

  // Suspend flags and busy; a core suspend beats a same-cycle flag clear, a resume beats a same-cycle busy clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag   <= 1'b0;
      busy                   <= 1'b0;
    end
    else
    begin
      if (prog_suspend_set)
        program_suspended_flag <= 1'b1;
      else if (do_resume || do_reset)
        program_suspended_flag <= 1'b0;
      if (erase_suspend_set)
        erase_suspended_flag <= 1'b1;
      else if (do_resume || do_reset)
        erase_suspended_flag <= 1'b0;
      if (do_resume)
        busy <= 1'b1;
      else if (do_reset || op_done || prog_suspend_set
               || erase_suspend_set)
        busy <= 1'b0;
    end
  end

  // One-cycle strobes to the array core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resume_prog  <= 1'b0;
      resume_erase <= 1'b0;
      soft_reset   <= 1'b0;
      op_abort     <= 1'b0;
    end
    else
    begin
      resume_prog  <= do_resume && program_suspended_flag;
      resume_erase <= do_resume && erase_suspended_flag;
      soft_reset   <= do_reset;
      op_abort     <= do_reset && busy;
    end
  end
endmodule : fsr_dev
`default_nettype wire

// ===== design/fsr_pkg.sv
/*
  Shared constants for both ends of the flash command slice: opcodes,
  frame lengths, timing counts and the discovery table contents.
  Assumes a 50 ns system clock on the host side.
*/
package fsr_pkg;
  localparam logic [7:0] OP_RESUME      = 8'h30;
  localparam logic [7:0] OP_NOP         = 8'h00;
  localparam logic [7:0] OP_RESET_ARM   = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC  = 8'h99;
  localparam logic [7:0] OP_READ_TABLE  = 8'h5A;
  localparam logic [7:0] OP_DUMMY_BYTE  = 8'h00;
  // Rising edges that carry the opcode in each mode
  localparam logic [6:0] SINGLE_OP_CLKS = 7'h08;
  localparam logic [6:0] QUAD_OP_CLKS   = 7'h02;
  // Edge after which the address has fully arrived
  localparam logic [6:0] ADDR_DONE_CLKS = 7'h20;
  // Opcode, three address bytes and one dummy byte
  localparam logic [6:0] DATA_START     = 7'h28;
  localparam logic [5:0] READ_HDR_BITS  = 6'h28;
  localparam logic [7:0] TABLE_LAST     = 8'h1F;
  localparam logic [7:0] UNUSED_BYTE    = 8'hFF;
  // Maker code placed in the second header; value is arbitrary
  localparam logic [7:0] TABLE_MAKER_ID = 8'h5E;
  // Timing
  localparam int CLK_NS               = 50;
  localparam int RESET_RECOVERY_NS    = 40000;
  localparam int RESUME_GAP_NS        = 20000;
  localparam int RESET_RECOVERY_CYC   = (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESUME_GAP_CYC       = (RESUME_GAP_NS + CLK_NS - 1) / CLK_NS;

  // Discovery table: signature and header area, FFh elsewhere
  function automatic logic [7:0] table_byte(input logic [7:0] a);
    logic [7:0] v;
    v = UNUSED_BYTE;
    case (a)
      8'h00: v = 8'h53;
      8'h01: v = 8'h46;
      8'h02: v = 8'h44;
      8'h03: v = 8'h50;
      8'h04: v = 8'h06;
      8'h05: v = 8'h01;
      8'h06: v = 8'h02;
      8'h08: v = 8'h00;
      8'h09: v = 8'h06;
      8'h0A: v = 8'h01;
      8'h0B: v = 8'h10;
      8'h0C: v = 8'h30;
      8'h0D: v = 8'h00;
      8'h0E: v = 8'h00;
      8'h10: v = TABLE_MAKER_ID;
      8'h11: v = 8'h00;
      8'h12: v = 8'h01;
      8'h13: v = 8'h04;
      8'h14: v = 8'h10;
      8'h15: v = 8'h01;
      8'h16: v = 8'h00;
      8'h18: v = 8'h84;
      8'h19: v = 8'h00;
      8'h1A: v = 8'h01;
      8'h1B: v = 8'h02;
      8'h1C: v = 8'hC0;
      8'h1D: v = 8'h00;
      8'h1E: v = 8'h00;
      default: v = UNUSED_BYTE;
    endcase
    return v;
  endfunction : table_byte
endpackage : fsr_pkg

// ===== design/fsr_if.sv
/*
  Serial flash link between host controller and device.
  Assumes idle lines float high (pull-ups) when nobody drives.
*/
`timescale 1ns/10ps
`default_nettype none
interface fsr_if;
  logic       cs_n;       // Chip select, active low
  logic       sclk;       // Serial clock made by the host
  logic [3:0] host_io_o;  // Host data out
  logic [3:0] host_io_oe; // Host drives lane
  logic [3:0] dev_io_o;   // Device data out
  logic [3:0] dev_io_oe;  // Device drives lane
  logic [3:0] io;         // Resolved lane levels

  // Undriven lanes read high as with pull-ups
  assign io = (dev_io_oe & dev_io_o) | (host_io_oe & host_io_o)
            | ~(dev_io_oe | host_io_oe);

  modport dev (input cs_n, input sclk, input io,
               output dev_io_o, output dev_io_oe);
  modport host (output cs_n, output sclk, output host_io_o,
                output host_io_oe, input io);
endinterface : fsr_if
`default_nettype wire

// ===== design/fsr_host.sv
/*
  Host end: divides its clock to make the link clock, sends one
  command frame per request and returns table bytes.
  Assumes HALF of at least 2 so the synchronised data lane settles
  before it is sampled at the end of each high phase.
*/
`timescale 1ns/10ps
`default_nettype none
module fsr_host #(
  parameter int HALF     = 4,                          // Clks/half
  parameter int RECOVERY = fsr_pkg::RESET_RECOVERY_CYC, // After reset
  parameter int GAP      = fsr_pkg::RESUME_GAP_CYC      // After resume
) (
  fsr_if.host              lnk,       // Link to device
  input  wire logic        clk,       // Host clock
  input  wire logic        rst_n,     // Async reset, low
  input  wire logic        cmd_valid, // Request present
  input  wire logic [7:0]  cmd_op,    // Opcode
  input  wire logic [23:0] cmd_addr,  // Table address
  input  wire logic [5:0]  cmd_len,   // Bytes to read, 0 = 64
  input  wire logic        quad_mode, // Send opcode on four lanes
  output logic             cmd_ready, // Idle, request taken
  output logic [7:0]       rd_data,   // Table byte
  output logic             rd_valid,  // Pulse: rd_data valid
  output logic             cmd_done   // Pulse: frame closed
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SEND = 5'b00010,
    H_READ = 5'b00100,
    H_END  = 5'b01000,
    H_WAIT = 5'b10000
  } fsr_hst_e;

  fsr_hst_e    st_q;
  logic [7:0]  ph_q;
  logic        tick;
  logic        sclk_q;
  logic        cs_n_q;
  logic [3:0]  io_o_q;
  logic [3:0]  io_oe_q;
  logic [39:0] sh_q;
  logic [5:0]  left_q;
  logic [5:0]  len_q;
  logic [7:0]  rx_q;
  logic [2:0]  rxn_q;
  logic        is_read_q;
  logic        quad_q;
  logic [15:0] wait_q;
  logic [15:0] hold_q;
  logic        io_s1_q;
  logic        io_s2_q;

  assign tick           = ph_q == 8'(HALF - 1);
  assign lnk.cs_n       = cs_n_q;
  assign lnk.sclk       = sclk_q;
  assign lnk.host_io_o  = io_o_q;
  assign lnk.host_io_oe = io_oe_q;

  // Device output lane passes two flops first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
    end
    else
    begin
      io_s1_q <= lnk.io[1];
      io_s2_q <= io_s1_q;
    end
  end

  // Half-period divider for the link clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ph_q <= 8'h00;
    else if (st_q == H_IDLE || st_q == H_WAIT || tick)
      ph_q <= 8'h00;
    else
      ph_q <= ph_q + 8'h01;
  end

  // Frame sequencer: data changes on falling, device samples rising
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q      <= H_IDLE;
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      io_o_q    <= 4'h0;
      io_oe_q   <= 4'h0;
      sh_q      <= 40'h00_0000_0000;
      left_q    <= 6'h00;
      len_q     <= 6'h00;
      rx_q      <= 8'h00;
      rxn_q     <= 3'h0;
      is_read_q <= 1'b0;
      quad_q    <= 1'b0;
      wait_q    <= 16'h0000;
      hold_q    <= 16'h0000;
      cmd_ready <= 1'b0;
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
      cmd_done  <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      cmd_done <= 1'b0;
      case (st_q)
        H_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            cs_n_q    <= 1'b0;
            quad_q    <= quad_mode;
            is_read_q <= cmd_op == fsr_pkg::OP_READ_TABLE && !quad_mode;
            sh_q      <= {cmd_op, cmd_addr, fsr_pkg::OP_DUMMY_BYTE};
            len_q     <= cmd_len;
            rxn_q     <= 3'h0;
            if (cmd_op == fsr_pkg::OP_READ_TABLE && !quad_mode)
              left_q <= fsr_pkg::READ_HDR_BITS;
            else
              left_q <= quad_mode ? 6'(fsr_pkg::QUAD_OP_CLKS)
                                  : 6'(fsr_pkg::SINGLE_OP_CLKS);
            io_o_q    <= quad_mode ? cmd_op[7:4] : {3'b000, cmd_op[7]};
            io_oe_q   <= quad_mode ? 4'hF : 4'h1;
            // Quiet time after the frame
            if (cmd_op == fsr_pkg::OP_RESET_EXEC)
              hold_q <= 16'(RECOVERY + HALF);
            else if (cmd_op == fsr_pkg::OP_RESUME)
              hold_q <= 16'(GAP + HALF);
            else
              hold_q <= 16'(HALF);
            st_q      <= H_SEND;
          end
        end
        H_SEND:
        begin
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (!sclk_q)
              left_q <= left_q - 6'h01;
            else if (left_q == 6'h00)
            begin
              io_oe_q <= 4'h0;
              st_q    <= is_read_q ? H_READ : H_END;
            end
            else if (quad_q)
            begin
              sh_q   <= {sh_q[35:0], 4'h0};
              io_o_q <= sh_q[35:32];
            end
            else
            begin
              sh_q   <= {sh_q[38:0], 1'b0};
              io_o_q <= {3'b000, sh_q[38]};
            end
          end
        end
        H_READ:
        begin
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (sclk_q)
            begin
              rx_q  <= {rx_q[6:0], io_s2_q};
              rxn_q <= rxn_q + 3'h1;
              if (rxn_q == 3'h7)
              begin
                rd_data  <= {rx_q[6:0], io_s2_q};
                rd_valid <= 1'b1;
                len_q    <= len_q - 6'h01;
                if (len_q == 6'h01)
                  st_q <= H_END;
              end
            end
          end
        end
        H_END:
        begin
          if (tick)
          begin
            cs_n_q   <= 1'b1;
            cmd_done <= 1'b1;
            wait_q   <= hold_q;
            st_q     <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          if (wait_q == 16'h0000)
            st_q <= H_IDLE;
          else
            wait_q <= wait_q - 16'h0001;
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end
endmodule : fsr_host
`default_nettype wire

// ===== bench/fsr_asserts.sv
/*
  Link checker: watches the wire between host and device ends.
  Assumes host divider HALF of 4 and both ends on one core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fsr_asserts (
  input wire logic       clk,        // Core clock
  input wire logic       rst_n,      // Async reset, low
  input wire logic       cs_n,       // Chip select
  input wire logic       sclk,       // Link clock
  input wire logic [3:0] host_io_o,  // Host lanes
  input wire logic [3:0] host_io_oe, // Host enables
  input wire logic [3:0] dev_io_oe   // Device enables
);
  logic [5:0] rise_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Rising link edges in the frame; saturates so long reads stay high
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      rise_q <= 6'h00;
    else if (rise_q != 6'h3F)
      rise_q <= rise_q + 6'h01;
  end

  chk_idle_released: assert property (cs_n |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  chk_out_after_hdr: assert property (dev_io_oe[1] |-> rise_q >= 6'h28)
    else $error("device output before header done");
  chk_out_in_data: assert property (!cs_n && rise_q >= 6'h29 |-> dev_io_oe[1])
    else $error("device silent in data phase");
  chk_single_lane: assert property (dev_io_oe[0] == 1'b0 && dev_io_oe[3:2] == 2'h0)
    else $error("device drives a wrong lane");
  chk_no_contention: assert property (dev_io_oe[1] |-> !host_io_oe[1])
    else $error("both ends drive lane one");
  chk_take_drives: assert property ($fell(cs_n) |-> host_io_oe[0])
    else $error("opcode lane not driven at select");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside frame");
  chk_data_hold: assert property (sclk && $past(sclk) |-> $stable(host_io_o))
    else $error("host data moved while clock high");
  chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("deselect too short");

  cov_table_data: cover property ($rose(dev_io_oe[1]));
  cov_quad_frame: cover property (!cs_n && rise_q == 6'h02 ##1 cs_n);
  cov_single_frame: cover property (!cs_n && rise_q == 6'h08 ##1 cs_n);
endmodule : fsr_asserts
`default_nettype wire

// ===== bench/flash_resume_reset_sfdp_bench.sv
/*
  Self-checking bench: host and device ends joined by the link.
  Assumes host HALF of 4 and shortened recovery and gap counts.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_resume_reset_sfdp_bench;
  logic        clk, rst_n, cmd_valid, quad_mode, perf_mode, op_done;
  logic        prog_suspend_set, erase_suspend_set;
  logic [7:0]  cmd_op, rd_data;
  logic [23:0] cmd_addr;
  logic [5:0]  cmd_len;
  logic        cmd_ready, rd_valid, cmd_done, busy, reset_armed;
  logic        program_suspended_flag, erase_suspended_flag;
  logic        resume_prog, resume_erase, soft_reset, op_abort;
  logic [7:0]  rx [$];
  logic [7:0]  exp_tab [0:32];
  int          errors, comparisons, n_rp, n_re, n_sr, n_ab;
  int          idle_wait;

  fsr_if lnk ();
  fsr_host #(.HALF(4), .RECOVERY(5), .GAP(3)) i_fsr_host (
    .lnk(lnk), .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .quad_mode(quad_mode), .cmd_ready(cmd_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_done(cmd_done));
  fsr_dev i_fsr_dev (
    .lnk(lnk), .clk(clk), .rst_n(rst_n), .quad_mode(quad_mode),
    .perf_mode(perf_mode), .prog_suspend_set(prog_suspend_set),
    .erase_suspend_set(erase_suspend_set), .op_done(op_done),
    .program_suspended_flag(program_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag), .busy(busy),
    .reset_armed(reset_armed), .resume_prog(resume_prog),
    .resume_erase(resume_erase), .soft_reset(soft_reset),
    .op_abort(op_abort));
  fsr_asserts i_fsr_asserts (
    .clk(clk), .rst_n(rst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .host_io_o(lnk.host_io_o), .host_io_oe(lnk.host_io_oe),
    .dev_io_oe(lnk.dev_io_oe));

  // Core clock, 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse outputs last one cycle, so count them as they pass
  always @(posedge clk)
  begin
    if (resume_prog === 1'b1) n_rp++;
    if (resume_erase === 1'b1) n_re++;
    if (soft_reset === 1'b1) n_sr++;
    if (op_abort === 1'b1) n_ab++;
  end

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Ends on a falling edge with the host idle again
  // Counts falling edges until idle; a hang counts as a mismatch
  task automatic wait_ready();
    idle_wait = 0;
    while (cmd_ready !== 1'b1 && idle_wait < 3000)
    begin
      @(negedge clk);
      idle_wait++;
    end
    if (idle_wait >= 3000) errors++;
  endtask : wait_ready

  // One frame; the device has acted by the time the host is idle
  task automatic send(input logic [7:0] op, input logic [23:0] addr,
                      input logic [5:0] len);
    int k;
    k = 0;
    rx.delete();
    wait_ready();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && k < 5000)
    begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) rx.push_back(rd_data);
      k++;
    end
    if (k >= 5000) errors++;
    wait_ready();
  endtask : send

  // Core event pulse: 0 program suspend, 1 erase suspend, 2 done
  task automatic pulse(input int which);
    prog_suspend_set = (which == 0);
    erase_suspend_set = (which == 1);
    op_done = (which == 2);
    @(negedge clk);
    {prog_suspend_set, erase_suspend_set, op_done} = 3'h0;
    repeat (2) @(negedge clk);
  endtask : pulse

  task automatic t_table();
    send(fsr_pkg::OP_READ_TABLE, 24'h000000, 6'h21);
    cmp("table length", 8'h21, 8'(rx.size()));
    foreach (rx[i]) cmp("table byte", exp_tab[i], rx[i]);
    send(fsr_pkg::OP_READ_TABLE, 24'h00001C, 6'h02);
    cmp("short length", 8'h02, 8'(rx.size()));
    cmp("pointer byte", 8'hC0, rx[0]);
  endtask : t_table

  task automatic t_resume();
    for (int w = 0; w < 2; w++)
    begin
      pulse(w);
      cmp("flags set", 8'(w ? 2 : 1),
          {6'h00, erase_suspended_flag, program_suspended_flag});
      send(fsr_pkg::OP_RESUME, 24'h000000, 6'h00);
      cmp("flags clear", 8'h00,
          {6'h00, erase_suspended_flag, program_suspended_flag});
      cmp("resume gap", 8'h01, 8'(idle_wait > 3));
      cmp("busy on", 8'h01, {7'h00, busy});
      cmp("restarts", w ? 8'h11 : 8'h01, {4'(n_re), 4'(n_rp)});
      pulse(2);
      cmp("busy off", 8'h00, {7'h00, busy});
    end
  endtask : t_resume

  task automatic t_perf();
    pulse(1);
    perf_mode = 1'b1;
    send(fsr_pkg::OP_RESUME, 24'h000000, 6'h00);
    cmp("held erase flag", 8'h01, {7'h00, erase_suspended_flag});
    cmp("no restart", 8'h01, 8'(n_re));
    perf_mode = 1'b0;
    send(fsr_pkg::OP_RESUME, 24'h000000, 6'h00);
    cmp("erase flag", 8'h00, {7'h00, erase_suspended_flag});
    pulse(2);
  endtask : t_perf

  task automatic t_disarm();
    send(fsr_pkg::OP_RESET_ARM, 24'h000000, 6'h00);
    cmp("armed", 8'h01, {7'h00, reset_armed});
    send(fsr_pkg::OP_NOP, 24'h000000, 6'h00);
    cmp("nop disarms", 8'h00, {7'h00, reset_armed});
    send(fsr_pkg::OP_RESET_EXEC, 24'h000000, 6'h00);
    cmp("no reset", 8'h00, 8'(n_sr));
    send(fsr_pkg::OP_RESET_ARM, 24'h000000, 6'h00);
    send(fsr_pkg::OP_READ_TABLE, 24'h000000, 6'h01);
    cmp("read disarms", 8'h00, {7'h00, reset_armed});
  endtask : t_disarm

  task automatic t_reset();
    pulse(0);
    send(fsr_pkg::OP_RESUME, 24'h000000, 6'h00);
    send(fsr_pkg::OP_RESET_ARM, 24'h000000, 6'h00);
    send(fsr_pkg::OP_RESET_EXEC, 24'h000000, 6'h00);
    cmp("recovery gap", 8'h01, 8'(idle_wait > 5));
    cmp("soft resets", 8'h01, 8'(n_sr));
    cmp("aborts", 8'h01, 8'(n_ab));
    cmp("busy reset", 8'h00, {7'h00, busy});
    pulse(1);
    send(fsr_pkg::OP_RESET_ARM, 24'h000000, 6'h00);
    send(fsr_pkg::OP_RESET_EXEC, 24'h000000, 6'h00);
    cmp("flag reset", 8'h00, {7'h00, erase_suspended_flag});
    cmp("idle no abort", 8'h01, 8'(n_ab));
  endtask : t_reset

  task automatic t_quad();
    quad_mode = 1'b1;
    send(fsr_pkg::OP_NOP, 24'h000000, 6'h00);
    pulse(0);
    send(fsr_pkg::OP_RESET_ARM, 24'h000000, 6'h00);
    cmp("quad armed", 8'h01, {7'h00, reset_armed});
    send(fsr_pkg::OP_RESET_EXEC, 24'h000000, 6'h00);
    cmp("quad reset", 8'h03, 8'(n_sr));
    cmp("quad flag", 8'h00, {7'h00, program_suspended_flag});
    quad_mode = 1'b0;
  endtask : t_quad

  // Main sequence
  initial
  begin
    exp_tab = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hFF,
      8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF,
      fsr_pkg::TABLE_MAKER_ID, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00,
      8'hFF, 8'h84, 8'h00, 8'h01, 8'h02, 8'hC0, 8'h00, 8'h00, 8'hFF, 8'hFF};
    {rst_n, cmd_valid, quad_mode, perf_mode, op_done} = 5'h00;
    {prog_suspend_set, erase_suspend_set} = 2'h0;
    cmd_op = 8'h00;
    cmd_addr = 24'h000000;
    cmd_len = 6'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_table();
    t_resume();
    t_perf();
    t_disarm();
    t_reset();
    t_quad();
    wrap_up();
  end

  // Watchdog: the run needs well under this many cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : flash_resume_reset_sfdp_bench
`default_nettype wire
